// *** design/dpf_top.sv ***
// Output control for the main and secondary phase/frequency detectors.
//
// Functional notes
// - Mode high: main polarity pin low gives positive, high gives negative.
// - Mode high: secondary polarity pin low gives positive, high gives negative.
// - Mode low: both detectors positive regardless of polarity pins.
// - Mode low forces crystal and lets reference bit steer output B.
// - Main positive: VCO fast sinks, slow sources, matched floats.
// - Main negative: VCO fast sources, slow sinks, matched floats.
// - Secondary positive: VCO fast pulses low, slow pulses high, matched floats.
// - Secondary negative: VCO fast pulses high, slow pulses low.
// - Gain bit selects high-to-low current ratio 4:1 clear, 8:1 set.
// - Top select clear: low bits pick none, low, high or both outputs.
// - Top select set: high output for 16/32/64/128 reference cycles, then low.
// - Main outputs not enabled by selection stay floating.
// - Main standby forces both main outputs floating.
// - Main float bit floats main outputs while counters run.
// - Secondary standby forces secondary output to high impedance.
// - Secondary float bit holds secondary output at high impedance.
// - Float bit changes wait until any pulse in progress has ended.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module dpf_top
  import dpf_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              mode_pin,
  input  wire logic              main_polarity_in,
  output logic                   main_polarity_out,
  output logic                   main_polarity_oe,
  input  wire logic              secondary_polarity_in,
  output logic                   secondary_polarity_out,
  output logic                   secondary_polarity_oe,
  input  wire logic              main_divided_vco,
  input  wire logic              main_divided_reference,
  input  wire logic              secondary_divided_vco,
  input  wire logic              secondary_divided_reference,
  output dpf_cp_t                main_detector_high_current_out,
  output dpf_cp_t                main_detector_low_current_out,
  output logic                   secondary_detector_out,
  output logic                   secondary_detector_out_oe,
  output logic                   gain_ratio_out,
  output logic                   reference_external,
  output logic                   output_b_out,
  output logic                   output_b_oe
);

  dpf_st_t         r;
  dpf_st_t         n;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] rise;
  logic            neg_m;
  logic            neg_s;
  logic            main_act;
  logic            sec_act;
  logic            hi_en;
  logic            lo_en;
  logic [7:0]      adapt_limit;
  logic            sel_wr;
  dpf_stat_t       stat;

  assign pin_raw[PIN_MODE]  = mode_pin;
  assign pin_raw[PIN_POL_M] = main_polarity_in;
  assign pin_raw[PIN_POL_S] = secondary_polarity_in;
  assign pin_raw[PIN_FV_M]  = main_divided_vco;
  assign pin_raw[PIN_FR_M]  = main_divided_reference;
  assign pin_raw[PIN_FV_S]  = secondary_divided_vco;
  assign pin_raw[PIN_FR_S]  = secondary_divided_reference;

  assign rise = r.pin & ~r.pin_q;

  // The polarity pins are only trusted while mode is high; with mode low they are our outputs.
  assign neg_m = r.pin[PIN_MODE] & r.pin[PIN_POL_M];
  assign neg_s = r.pin[PIN_MODE] & r.pin[PIN_POL_S];

  assign main_act = ~r.ctl.main_stby & ~r.float_m_eff;
  assign sec_act  = ~r.ctl.sec_stby & ~r.float_s_eff;

  assign adapt_limit = 8'(ADAPT_BASE << r.sel.code);
  assign sel_wr      = reg_wr && (reg_addr == REG_SEL);

  // Output selection: fixed codes, or the adapt timer handing the loop to the low output.
  always_comb
  begin
    if (!r.sel.top)
    begin
      hi_en = r.sel.code[1];
      lo_en = r.sel.code[0];
    end
    else
    begin
      hi_en = ~r.adapt_done;
      lo_en = r.adapt_done;
    end
  end

  always_comb
  begin
    stat             = '0;
    stat.pins        = r.pin;
    stat.float_m_eff = r.float_m_eff;
    stat.float_s_eff = r.float_s_eff;
    stat.adapt_done  = r.adapt_done;
    stat.up_m        = r.up_m;
    stat.dn_m        = r.dn_m;
    stat.up_s        = r.up_s;
    stat.dn_s        = r.dn_s;
    stat.adapt_cnt   = r.adapt_cnt;
  end

  always_comb
  begin
    n = r;

    // A pin level is accepted only once the second and third stages agree.
    n.s1 = pin_raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < NPIN; i++)
    begin
      if (r.s2[i] == r.s3[i])
      begin
        n.pin[i] = r.s3[i];
      end
    end
    n.pin_q = r.pin;

    // Register writes.
    if (reg_wr && (reg_addr == REG_CTRL))
    begin
      n.ctl.sec_stby   = reg_wdata[CTL_SEC_STBY];
      n.ctl.main_stby  = reg_wdata[CTL_MAIN_STBY];
      n.ctl.sec_float  = reg_wdata[CTL_SEC_FLOAT];
      n.ctl.main_float = reg_wdata[CTL_MAIN_FLOAT];
      n.ctl.ref_src    = reg_wdata[CTL_REF_SRC];
    end
    else if (sel_wr)
    begin
      n.sel.gain = reg_wdata[SEL_GAIN];
      n.sel.code = {reg_wdata[SEL_MID], reg_wdata[SEL_LOW]};
      n.sel.top  = reg_wdata[SEL_TOP];
    end

    // Read data stands only in the cycle after the read strobe.
    n.rdata = '0;
    if (reg_rd)
    begin
      if (reg_addr == REG_CTRL)
      begin
        n.rdata[CTL_SEC_STBY]   = r.ctl.sec_stby;
        n.rdata[CTL_MAIN_STBY]  = r.ctl.main_stby;
        n.rdata[CTL_SEC_FLOAT]  = r.ctl.sec_float;
        n.rdata[CTL_MAIN_FLOAT] = r.ctl.main_float;
        n.rdata[CTL_REF_SRC]    = r.ctl.ref_src;
      end
      else if (reg_addr == REG_SEL)
      begin
        n.rdata[SEL_GAIN] = r.sel.gain;
        n.rdata[SEL_LOW]  = r.sel.code[0];
        n.rdata[SEL_MID]  = r.sel.code[1];
        n.rdata[SEL_TOP]  = r.sel.top;
      end
      else if (reg_addr == REG_STAT)
      begin
        n.rdata = stat;
      end
    end

    // Detector cores: reference edge arms up, VCO edge arms down, coincidence clears both.
    // Counters keep running in float and standby; only the drivers are gated.
    n.up_m = r.up_m | rise[PIN_FR_M];
    n.dn_m = r.dn_m | rise[PIN_FV_M];
    if (n.up_m && n.dn_m)
    begin
      n.up_m = 1'b0;
      n.dn_m = 1'b0;
    end
    n.up_s = r.up_s | rise[PIN_FR_S];
    n.dn_s = r.dn_s | rise[PIN_FV_S];
    if (n.up_s && n.dn_s)
    begin
      n.up_s = 1'b0;
      n.dn_s = 1'b0;
    end

    // Float requests are deferred so that a pulse is never cut short.
    if (!(r.up_m || r.dn_m))
    begin
      n.float_m_eff = r.ctl.main_float;
    end
    if (!(r.up_s || r.dn_s))
    begin
      n.float_s_eff = r.ctl.sec_float;
    end

    // Adapt timer restarts on every selection write that sets the top bit.
    if (sel_wr && reg_wdata[SEL_TOP])
    begin
      n.adapt_cnt  = '0;
      n.adapt_done = 1'b0;
    end
    else if (r.sel.top && !r.adapt_done && rise[PIN_FR_M])
    begin
      n.adapt_cnt = r.adapt_cnt + 8'h01;
      if (n.adapt_cnt == adapt_limit)
      begin
        n.adapt_done = 1'b1;
      end
    end

    // Main drivers: sink on VCO-ahead in positive polarity, swapped in negative.
    n.hi_out.source = main_act & hi_en & (neg_m ? r.dn_m : r.up_m);
    n.hi_out.sink   = main_act & hi_en & (neg_m ? r.up_m : r.dn_m);
    n.lo_out.source = main_act & lo_en & (neg_m ? r.dn_m : r.up_m);
    n.lo_out.sink   = main_act & lo_en & (neg_m ? r.up_m : r.dn_m);

    // Secondary driver: voltage output, high impedance between pulses.
    n.sec_oe  = sec_act & (r.up_s | r.dn_s);
    n.sec_out = neg_s ? r.dn_s : r.up_s;

    // The polarity pins turn outward while mode is low; their signal is generated elsewhere.
    n.pol_oe    = ~r.pin[PIN_MODE];
    n.pol_level = 1'b0;

    n.ref_ext  = r.pin[PIN_MODE] & r.ctl.ref_src;
    n.outb_oe  = ~r.pin[PIN_MODE] & ~r.ctl.main_stby;
    n.outb_out = r.ctl.ref_src;
    n.gain_out = r.sel.gain;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r     <= '0;
      r.ctl <= CTL_RESET;
      r.sel <= SEL_RESET;
      // Mode reads high until its pin is known, so the polarity pins never fight an outside driver.
      r.s1[PIN_MODE]  <= 1'b1;
      r.s2[PIN_MODE]  <= 1'b1;
      r.s3[PIN_MODE]  <= 1'b1;
      r.pin[PIN_MODE] <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign reg_rdata                      = r.rdata;
  assign main_polarity_out              = r.pol_level;
  assign main_polarity_oe               = r.pol_oe;
  assign secondary_polarity_out         = r.pol_level;
  assign secondary_polarity_oe          = r.pol_oe;
  assign main_detector_high_current_out = r.hi_out;
  assign main_detector_low_current_out  = r.lo_out;
  assign secondary_detector_out         = r.sec_out;
  assign secondary_detector_out_oe      = r.sec_oe;
  assign gain_ratio_out                 = r.gain_out;
  assign reference_external             = r.ref_ext;
  assign output_b_out                   = r.outb_out;
  assign output_b_oe                    = r.outb_oe;

  chk_mode_low_positive: assert property (@(posedge clock) disable iff (!nrst)
    (!r.pin[PIN_MODE] && r.dn_m && main_act && lo_en) |=> main_detector_low_current_out.sink)
    else $error("Main detector not positive with mode low.");

  chk_main_neg_pol: assert property (@(posedge clock) disable iff (!nrst)
    (r.pin[PIN_MODE] && r.pin[PIN_POL_M] && r.dn_m && main_act && hi_en)
      |=> main_detector_high_current_out.source && !main_detector_high_current_out.sink)
    else $error("Main negative polarity not sourcing on VCO lead.");

  chk_main_pos_pol: assert property (@(posedge clock) disable iff (!nrst)
    (!neg_m && r.up_m && main_act && hi_en) |=> main_detector_high_current_out.source)
    else $error("Main positive polarity not sourcing on VCO lag.");

  chk_sec_pos_low: assert property (@(posedge clock) disable iff (!nrst)
    (!neg_s && r.dn_s && sec_act) |=> secondary_detector_out_oe && !secondary_detector_out)
    else $error("Secondary positive polarity not pulsing low.");

  chk_sec_neg_high: assert property (@(posedge clock) disable iff (!nrst)
    (neg_s && r.dn_s && sec_act) |=> secondary_detector_out_oe && secondary_detector_out)
    else $error("Secondary negative polarity not pulsing high.");

  chk_main_standby_float: assert property (@(posedge clock) disable iff (!nrst)
    r.ctl.main_stby |=> (main_detector_high_current_out == '0) && (main_detector_low_current_out == '0))
    else $error("Main outputs driven in standby.");

  chk_sec_standby_hiz: assert property (@(posedge clock) disable iff (!nrst)
    r.ctl.sec_stby |=> !secondary_detector_out_oe)
    else $error("Secondary output driven in standby.");

  chk_select_low_only: assert property (@(posedge clock) disable iff (!nrst)
    (!r.sel.top && r.sel.code == 2'h1) |=> (main_detector_high_current_out == '0))
    else $error("High output driven with low-only selection.");

  chk_adapt_exact: assert property (@(posedge clock) disable iff (!nrst)
    $rose(r.adapt_done) |-> (r.adapt_cnt == adapt_limit) && r.sel.top)
    else $error("Adapt handover at wrong count.");

  chk_float_held_pulse: assert property (@(posedge clock) disable iff (!nrst)
    (r.up_m || r.dn_m) |=> (r.float_m_eff == $past(r.float_m_eff)))
    else $error("Main float changed during a pulse.");

  chk_ref_crystal: assert property (@(posedge clock) disable iff (!nrst)
    !r.pin[PIN_MODE] |=> !reference_external)
    else $error("External reference selected with mode low.");

  chk_gain_follow: assert property (@(posedge clock) disable iff (!nrst)
    sel_wr |=> ##1 (gain_ratio_out == $past(reg_wdata[SEL_GAIN], 2)))
    else $error("Gain ratio output does not follow written bit.");

  chk_main_float_off: assert property (@(posedge clock) disable iff (!nrst)
    r.float_m_eff |=> (main_detector_high_current_out == '0) && (main_detector_low_current_out == '0))
    else $error("Main outputs driven while floating.");

  chk_sec_float_hiz: assert property (@(posedge clock) disable iff (!nrst)
    r.float_s_eff |=> !secondary_detector_out_oe)
    else $error("Secondary output driven while floating.");

  chk_select_none: assert property (@(posedge clock) disable iff (!nrst)
    (!r.sel.top && r.sel.code == 2'h0)
      |=> (main_detector_high_current_out == '0) && (main_detector_low_current_out == '0))
    else $error("Main output driven with no output selected.");

  chk_adapt_low_only: assert property (@(posedge clock) disable iff (!nrst)
    (r.sel.top && r.adapt_done) |=> (main_detector_high_current_out == '0))
    else $error("High output driven after adapt handover.");

  chk_main_neg_sink: assert property (@(posedge clock) disable iff (!nrst)
    (neg_m && r.up_m && main_act && lo_en)
      |=> main_detector_low_current_out.sink && !main_detector_low_current_out.source)
    else $error("Main negative polarity not sinking on VCO lag.");

  chk_outb_standby: assert property (@(posedge clock) disable iff (!nrst)
    r.ctl.main_stby |=> !output_b_oe)
    else $error("Output B driven with main loop in standby.");

endmodule : dpf_top

// *** common/dpf_pkg.sv ***
// Shared constants and types for the dual phase/frequency detector output control.
package dpf_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SEL  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;

  // Control register bit positions.
  localparam int unsigned CTL_SEC_STBY   = 0;
  localparam int unsigned CTL_MAIN_STBY  = 1;
  localparam int unsigned CTL_SEC_FLOAT  = 3;
  localparam int unsigned CTL_MAIN_FLOAT = 4;
  localparam int unsigned CTL_REF_SRC    = 6;

  // Selection register bit positions.
  localparam int unsigned SEL_GAIN = 0;
  localparam int unsigned SEL_LOW  = 1;
  localparam int unsigned SEL_MID  = 2;
  localparam int unsigned SEL_TOP  = 3;

  // Synchronised pin vector layout.
  localparam int unsigned NPIN      = 7;
  localparam int unsigned PIN_MODE  = 0;
  localparam int unsigned PIN_POL_M = 1;
  localparam int unsigned PIN_POL_S = 2;
  localparam int unsigned PIN_FV_M  = 3;
  localparam int unsigned PIN_FR_M  = 4;
  localparam int unsigned PIN_FV_S  = 5;
  localparam int unsigned PIN_FR_S  = 6;

  // Adapt timer: shortest interval in reference cycles, doubled per code step.
  localparam int unsigned ADAPT_W    = 8;
  localparam logic [7:0]  ADAPT_BASE = 8'h10;

  typedef struct packed {
    logic ref_src;
    logic main_float;
    logic sec_float;
    logic main_stby;
    logic sec_stby;
  } dpf_ctl_t;

  typedef struct packed {
    logic       top;
    logic [1:0] code;
    logic       gain;
  } dpf_sel_t;

  localparam dpf_ctl_t CTL_RESET = '{ref_src: 1'b0, main_float: 1'b0, sec_float: 1'b0,
                                     main_stby: 1'b1, sec_stby: 1'b1};
  localparam dpf_sel_t SEL_RESET = '{top: 1'b0, code: 2'h0, gain: 1'b0};

  // One three-state current output: at most one of the two is high, neither means floating.
  typedef struct packed {
    logic source;
    logic sink;
  } dpf_cp_t;

  // Status word as read back.
  typedef struct packed {
    logic [7:0]      pad_hi;
    logic [7:0]      adapt_cnt;
    logic [1:0]      pad_lo;
    logic            dn_s;
    logic            up_s;
    logic            dn_m;
    logic            up_m;
    logic            adapt_done;
    logic            float_s_eff;
    logic            float_m_eff;
    logic [NPIN-1:0] pins;
  } dpf_stat_t;

  typedef struct packed {
    logic [NPIN-1:0]   s1;
    logic [NPIN-1:0]   s2;
    logic [NPIN-1:0]   s3;
    logic [NPIN-1:0]   pin;
    logic [NPIN-1:0]   pin_q;
    dpf_ctl_t          ctl;
    dpf_sel_t          sel;
    logic              float_m_eff;
    logic              float_s_eff;
    logic              up_m;
    logic              dn_m;
    logic              up_s;
    logic              dn_s;
    logic [ADAPT_W-1:0] adapt_cnt;
    logic              adapt_done;
    dpf_cp_t           hi_out;
    dpf_cp_t           lo_out;
    logic              sec_out;
    logic              sec_oe;
    logic              pol_oe;
    logic              pol_level;
    logic              outb_out;
    logic              outb_oe;
    logic              ref_ext;
    logic              gain_out;
    logic [DATA_W-1:0] rdata;
  } dpf_st_t;

endpackage : dpf_pkg

// *** test/dpf_loop_model.sv ***
// Behavioural model of the dividers that feed the detector inputs.
`timescale 1ns/100ps
module dpf_loop_model
  import dpf_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       go,
  input  wire logic       ref_first,
  input  wire logic [3:0] gap,
  output logic            fv,
  output logic            fr
);
  logic [4:0] cnt_r;
  logic       ref_first_r;
  logic [3:0] gap_r;
  logic       act;

  // One frame: the leading divider rises at count 0, the lagging one gap cycles later.
  // Both fall at count 16 and stand still until the next frame, so no stray edges reach the detector.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r       <= 5'h1f;
      ref_first_r <= 1'b0;
      gap_r       <= 4'h0;
    end
    else if (go)
    begin
      cnt_r       <= 5'h00;
      ref_first_r <= ref_first;
      gap_r       <= gap;
    end
    else if (cnt_r != 5'h1f)
      cnt_r <= cnt_r + 5'h01;
  end

  assign act = cnt_r < 5'h10;
  assign fr  = act && (ref_first_r || cnt_r >= {1'b0, gap_r});
  assign fv  = act && (!ref_first_r || cnt_r >= {1'b0, gap_r});
endmodule : dpf_loop_model

// *** test/tb.sv ***
// Self-checking testbench for the dual detector output control.
`timescale 1ns/100ps
module tb
  import dpf_pkg::*;
;
  localparam logic T = 1'b1;
  localparam logic F = 1'b0;
  logic              clock, nrst, reg_wr, reg_rd, mode, pol_m, pol_s, go, rf, fv, fr;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rdv;
  logic [3:0]        gap;
  logic [5:0]        seen;
  dpf_cp_t           hi, lo;
  logic              sec_o, sec_oe, pm_o, pm_oe, ps_o, ps_oe, gain_o, ref_ext, ob_o, ob_oe;
  int                n_mismatch, n_compared;
  int                shv[4] = '{4, 3, 1, 0};
  // The bench lets go of the polarity pins whenever the block drives them.
  // A driven pin carries the frequency output made outside the block; shown high, so reading it would show.
  wire               pm_w = pm_oe ? 1'b1 : pol_m;
  wire               ps_w = ps_oe ? 1'b1 : pol_s;

  dpf_top dpf_top_inst (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_pin(mode), .main_polarity_in(pm_w),
    .main_polarity_out(pm_o), .main_polarity_oe(pm_oe), .secondary_polarity_in(ps_w),
    .secondary_polarity_out(ps_o), .secondary_polarity_oe(ps_oe), .main_divided_vco(fv),
    .main_divided_reference(fr), .secondary_divided_vco(fv), .secondary_divided_reference(fr),
    .main_detector_high_current_out(hi), .main_detector_low_current_out(lo),
    .secondary_detector_out(sec_o), .secondary_detector_out_oe(sec_oe), .gain_ratio_out(gain_o),
    .reference_external(ref_ext), .output_b_out(ob_o), .output_b_oe(ob_oe));

  dpf_loop_model dpf_loop_model_inst (.clock(clock), .nrst(nrst), .go(go), .ref_first(rf), .gap(gap),
    .fv(fv), .fr(fr));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Runs one frame and gathers every output state seen: hi src/snk, lo src/snk, sec high/low.
  task automatic frame(input logic r, input logic [3:0] g, output logic [5:0] s);
    @(posedge clock);
    rf  <= r;
    gap <= g;
    go  <= 1'b1;
    @(posedge clock);
    go  <= 1'b0;
    s = 6'h00;
    repeat (28)
    begin
      @(posedge clock);
      #1 s |= {hi.source, hi.sink, lo.source, lo.sink, sec_oe & sec_o, sec_oe & ~sec_o};
    end
  endtask : frame

  function automatic logic [5:0] ex(input logic eh, el, es, nm, ns, r);
    logic m;
    logic q;
    m = r ^ nm;
    q = r ^ ns;
    return {eh & m, eh & ~m, el & m, el & ~m, es & q, es & ~q};
  endfunction : ex

  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    {reg_wr, reg_rd, go, rf, pol_m, pol_s} = 6'h00;
    mode = 1'b1;
    gap = 4'h8;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    nrst = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(REG_CTRL, rdv); chk("ctrl reset", 32'h3, rdv);
    rd(REG_SEL, rdv); chk("sel reset", 32'h0, rdv);
    wr(REG_STAT, 32'hffffffff);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, rdv); chk("unmapped", 32'h0, rdv);
    rd(REG_CTRL, rdv); chk("ctrl kept", 32'h3, rdv);
    wr(REG_SEL, 32'h6);
    frame(T, 4'h8, seen); chk("standby", 32'h0, {26'h0, seen});
    wr(REG_CTRL, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clock);
      mode  <= (i < 4);
      pol_m <= (i > 1);
      pol_s <= (i > 1);
      repeat (8) @(posedge clock);
      #1 chk("pol oe", {31'h0, i >= 4}, {31'h0, pm_oe & ps_oe});
      chk("pol out", 32'h0, {30'h0, pm_o, ps_o});
      frame(i[0], 4'h8, seen);
      chk("polarity", {26'h0, ex(T, T, T, i == 2 || i == 3, i == 2 || i == 3, i[0])}, {26'h0, seen});
    end
    @(posedge clock);
    mode  <= 1'b1;
    pol_m <= 1'b0;
    pol_s <= 1'b0;
    repeat (8) @(posedge clock);
    for (int c = 0; c < 3; c++)
    begin
      wr(REG_SEL, 32'(c * 2 + c % 2));
      frame(T, 4'h8, seen); chk("select", {26'h0, ex(c[1], c[0], T, F, F, T)}, {26'h0, seen});
      chk("gain", 32'(c % 2), {31'h0, gain_o});
    end
    wr(REG_SEL, 32'h6);
    for (int j = 0; j < 4; j++)
    begin
      wr(REG_CTRL, 32'h1 << shv[j]);
      frame(T, 4'h8, seen);
      chk("float stby", {26'h0, ex(shv[j] == 3 || shv[j] == 0, shv[j] == 3 || shv[j] == 0,
        shv[j] == 4 || shv[j] == 1, F, F, T)}, {26'h0, seen});
    end
    wr(REG_CTRL, 32'h0);
    @(posedge clock);
    rf  <= 1'b1;
    gap <= 4'hc;
    go  <= 1'b1;
    @(posedge clock);
    go  <= 1'b0;
    repeat (7) @(posedge clock);
    wr(REG_CTRL, 32'h10);
    repeat (2) @(posedge clock);
    #1 chk("float deferred", 32'h2, {30'h0, hi});
    repeat (25) @(posedge clock);
    frame(T, 4'h8, seen); chk("float late", {26'h0, ex(F, F, T, F, F, T)}, {26'h0, seen});
    wr(REG_CTRL, 32'h0);
    // Each frame carries exactly one reference rise, so frame k is the k-th counted cycle.
    for (int c = 0; c < 4; c++)
    begin
      wr(REG_SEL, 32'(8 + 2 * c));
      for (int k = 1; k <= (16 << c) + 1; k++)
      begin
        frame(T, 4'h8, seen);
        if (k == (16 << c) - 1)
          chk("adapt high", {26'h0, ex(T, F, T, F, F, T)}, {26'h0, seen});
        if (k == (16 << c) + 1)
          chk("adapt low", {26'h0, ex(F, T, T, F, F, T)}, {26'h0, seen});
      end
    end
    rd(REG_STAT, rdv); chk("status", 32'h00800201, rdv);
    @(posedge clock);
    mode <= 1'b0;
    wr(REG_CTRL, 32'h41);
    repeat (8) @(posedge clock);
    #1 chk("out b", 32'h6, {29'h0, ob_oe, ob_o, ref_ext});
    wr(REG_CTRL, 32'h43);
    repeat (3) @(posedge clock);
    #1 chk("out b stby", 32'h0, {31'h0, ob_oe});
    @(posedge clock);
    mode <= 1'b1;
    repeat (8) @(posedge clock);
    #1 chk("ext ref", 32'h2, {30'h0, ref_ext, ob_oe});
    final_report();
  end
endmodule : tb
